/* core/lsi_pkg.sv */
// Shared constants and types for the LVDS sample input synchronizer
package lsi_pkg;

  // Sample word and converter codes
  localparam int DW = 16;
  localparam int FIFO_DEPTH = 16;
  typedef logic [DW-1:0] lsi_word_t;
  localparam lsi_word_t MID_CODE = 16'h0000;
  localparam lsi_word_t ZERO_WORD = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, in picoseconds and in core_clk cycles
  localparam int CORE_PS = 8000;
  localparam int DCLK_MIN_MHZ = 25;
  localparam int DCLK_MAX_PERIOD_PS = 1000000 / DCLK_MIN_MHZ;
  // A longest time, so it rounds down
  localparam int DCLK_MAX_PERIOD_CYC = DCLK_MAX_PERIOD_PS / CORE_PS;
  localparam int EA_DELAY_PS = 400;
  localparam int TRIM_STEP_PS = 85;
  localparam int HIST_W = 4;
  localparam int GAP_W = 4;
  localparam logic [1:0] PH_OFFSET = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Serial register port framing
  localparam int SPI_BITS = 16;
  localparam int SPI_HDR_BITS = 8;
  localparam int SPI_CNT_W = 5;
  typedef enum logic [1:0] {
    SPI_IDLE = 2'h0,
    SPI_SHIFT = 2'h1,
    SPI_DONE = 2'h3
  } lsi_spi_st_t;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and field positions
  localparam logic [6:0] ADDR_CLK_CTL = 7'h03;
  localparam logic [6:0] ADDR_PORT_CTL = 7'h04;
  localparam logic [6:0] ADDR_PH_CTL = 7'h05;
  localparam logic [6:0] ADDR_PH_OBS = 7'h06;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CLK_EN_BIT = 0;
  localparam int CLK_OK_BIT = 1;
  localparam int CLK_Q_BIT = 2;
  localparam int TRIM_LSB = 4;
  localparam int TRIM_MSB = 6;
  localparam int PORT_A_BIT = 0;
  localparam int PORT_B_BIT = 1;
  localparam int SP_BIT = 2;
  localparam int UPD_BIT = 3;
  localparam int PS_MSB = 1;
  localparam int MSYN_BIT = 2;

endpackage

/* core/lsi_fifo_if.sv */
// Handshake carrier between the capture path and the sample FIFO
`timescale 1ns/1ps
interface lsi_fifo_if #(parameter int W = 16);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;

  modport fifo (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data
  );
endinterface

/* core/lsi_fifo.sv */
// Sample FIFO with valid/ready on both sides and a synchronous flush
`timescale 1ns/1ps
module lsi_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic flush,
  lsi_fifo_if.fifo bus
);
  import lsi_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } lsi_fifo_state_t;

  lsi_fifo_state_t s;
  lsi_fifo_state_t next_s;
  logic push_fire;
  logic pop_fire;

  assign bus.push_ready = s.cnt != (AW + 1)'(DEPTH);
  assign bus.pop_valid = s.cnt != '0;
  assign bus.pop_data = s.mem[s.rp];
  assign push_fire = bus.push_valid & bus.push_ready;
  assign pop_fire = bus.pop_valid & bus.pop_ready;

  always_comb
  begin
    next_s = s;
    if (push_fire)
    begin
      next_s.mem[s.wp] = bus.push_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (pop_fire)
      next_s.rp = s.rp + 1'b1;
    if (push_fire && !pop_fire)
      next_s.cnt = s.cnt + 1'b1;
    else if (pop_fire && !push_fire)
      next_s.cnt = s.cnt - 1'b1;
    // Flush drops everything, including a push in the same cycle
    if (flush)
    begin
      next_s.wp = '0;
      next_s.rp = '0;
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

endmodule

/* core/lsi_sync.sv */
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module lsi_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lsi_sync_state_t;

  lsi_sync_state_t s;
  lsi_sync_state_t next_s;

  assign q = s.s2;

  always_comb
  begin
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

endmodule

/* core/lsi_top.sv */
// DDR sample input capture, clock detection, phase steering and registers
`timescale 1ns/1ps
//
// Behaviour
// - Data clock receiver runs only when enabled
// - Present flag set only above 25 MHz
// - No data clock: mid-scale, path in reset
// - Quadrature mode: clock and data delays matched
// - Edge-aligned mode: clock delayed nominal 400 ps
// - Trim moves clock delay in 85 ps steps
// - Samples are two's complement converter codes
// - One word per port on every edge
// - Single-port mode takes port B only
// - Dual-port mode takes both ports
// - Port A disabled presents zero words
// - Port B disabled presents zero words
// - Single-port select chooses B-only or both
// - Update enable clear forces mid-scale
// - Dual mode emits port A before B
// - Comparators track drift, steer mux phase
// - Comparator result readable at register six
// - Auto mode sets mux phase, read-only
// - Manual mode uses written mux phase
// - Phase bits 1:0, override bit 2
// - Pattern generator exempts missing-clock mute
// - Quadrature bit 2, trim bits 6:4
module lsi_top #(
  parameter int DCLK_LIMIT_CYC = lsi_pkg::DCLK_MAX_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic ddr_capture_clock_pair,
  input wire lsi_pkg::lsi_word_t first_port_pairs,
  input wire lsi_pkg::lsi_word_t second_port_pairs,
  input wire logic pattern_gen_enable,
  input wire logic dac_ready,
  output lsi_pkg::lsi_word_t dac_code,
  output logic dac_code_valid,
  output logic data_clock_present,
  output logic data_clock_rx_enable,
  output logic port_a_rx_enable,
  output logic port_b_rx_enable
);
  import lsi_pkg::*;

  typedef struct packed {
    lsi_spi_st_t spi_st;
    logic sck_d;
    logic [SPI_BITS-1:0] sin;
    logic [SPI_CNT_W-1:0] cnt;
    logic [7:0] sout;
    logic rd;
    logic clk_en;
    logic q;
    logic [2:0] trim;
    logic [3:0] port;
    logic msyn;
    logic [1:0] ps;
    logic [HIST_W-1:0] hist;
    logic [GAP_W-1:0] gap;
    logic present;
    logic [1:0] div;
    logic [7:0] result;
    lsi_word_t hold_a;
    lsi_word_t hold_b;
    logic hold_full;
    lsi_word_t pair_a;
    lsi_word_t pair_b;
    logic [1:0] pend;
    lsi_word_t code;
    logic code_vld;
  } lsi_main_state_t;

  lsi_main_state_t s;
  lsi_main_state_t next_s;

  logic dclk_s;
  lsi_word_t a_s;
  lsi_word_t b_s;
  logic cs_n_s;
  logic sck_s;
  logic sdi_s;
  logic dclk_g;
  logic sck_rise;
  logic sck_fall;
  logic shifting;
  logic hdr_load;
  logic spi_wr;
  logic [7:0] frame_byte;
  int tap_ps;
  int tap_cyc;
  logic [1:0] tap_sel;
  logic d_now;
  logic d_prev;
  logic dck_edge;
  logic dck_rise;
  logic xfer;
  logic push_fire;
  logic single;
  logic mute;

  lsi_fifo_if #(.W(DW)) fq ();

  lsi_sync #(.W(2 * DW + 4)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .d({ddr_capture_clock_pair, first_port_pairs, second_port_pairs,
        spi_cs_n, spi_sck, spi_sdi}),
    .q({dclk_s, a_s, b_s, cs_n_s, sck_s, sdi_s})
  );

  lsi_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .flush(!s.present),
    .bus(fq.fifo)
  );

  assign spi_sdo = s.sout[7];
  assign spi_sdo_oe = shifting && s.rd &&
                      s.cnt >= SPI_CNT_W'(SPI_HDR_BITS);
  assign dac_code = s.code;
  assign dac_code_valid = s.code_vld;
  assign data_clock_present = s.present;
  assign data_clock_rx_enable = s.clk_en;
  assign port_a_rx_enable = s.port[PORT_A_BIT];
  assign port_b_rx_enable = s.port[PORT_B_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Serial register port decode
  assign sck_rise = sck_s & ~s.sck_d;
  assign sck_fall = ~sck_s & s.sck_d;
  assign shifting = s.spi_st == SPI_SHIFT && !cs_n_s;
  assign frame_byte = {s.sin[6:0], sdi_s};
  assign hdr_load = shifting && sck_rise &&
                    s.cnt == SPI_CNT_W'(SPI_HDR_BITS - 1);
  assign spi_wr = shifting && sck_rise && !s.rd &&
                  s.cnt == SPI_CNT_W'(SPI_BITS - 1);

  function automatic logic [7:0] rd_mux(input logic [6:0] a);
    logic [7:0] v;
    v = REG_RESET;
    case (a)
      ADDR_CLK_CTL:
      begin
        v[CLK_EN_BIT] = s.clk_en;
        v[CLK_OK_BIT] = s.present;
        v[CLK_Q_BIT] = s.q;
        v[TRIM_MSB:TRIM_LSB] = s.trim;
      end
      ADDR_PORT_CTL: v[3:0] = s.port;
      ADDR_PH_CTL:
      begin
        v[PS_MSB:0] = s.ps;
        v[MSYN_BIT] = s.msyn;
      end
      ADDR_PH_OBS: v = s.result;
      default: v = REG_RESET;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Clock delay tap: quadrature uses no delay, edge-aligned rounds up
  always_comb
  begin
    tap_ps = 0;
    if (!s.q)
      tap_ps = EA_DELAY_PS + int'($signed(s.trim)) * TRIM_STEP_PS;
    tap_cyc = (tap_ps + CORE_PS - 1) / CORE_PS;
    tap_sel = (tap_cyc > HIST_W - 2) ? 2'(HIST_W - 2) : 2'(tap_cyc);
  end

  assign dclk_g = dclk_s & s.clk_en;
  assign d_now = s.hist[tap_sel];
  assign d_prev = s.hist[tap_sel + 2'h1];
  assign dck_edge = d_now ^ d_prev;
  assign dck_rise = d_now & ~d_prev;
  assign single = s.port[SP_BIT];
  assign xfer = s.present && s.hold_full && s.pend == 2'h0 &&
                s.div == s.ps && !dck_edge;
  assign push_fire = fq.push_valid & fq.push_ready;
  // Pattern generator owns the code when the data clock is gone
  assign mute = !s.port[UPD_BIT] ||
                (!s.present && !pattern_gen_enable);

  assign fq.push_valid = s.pend != 2'h0;
  assign fq.push_data = (s.pend == 2'h2) ? s.pair_a : s.pair_b;
  assign fq.pop_ready = dac_ready;

  always_comb
  begin
    next_s = s;
    next_s.code_vld = 1'b0;
    next_s.sck_d = sck_s;

    // Clock detector and phase comparators
    next_s.hist = {s.hist[HIST_W-2:0], dclk_g};
    next_s.div = s.div + 2'h1;
    if (dck_rise)
    begin
      next_s.gap = GAP_W'(1);
      next_s.present = s.gap < GAP_W'(DCLK_LIMIT_CYC);
      next_s.result = {s.result[5:0], s.div[1], s.div[0]};
      // Follow only once two comparisons agree, so jitter cannot steer
      if (!s.msyn && s.result[1:0] == s.div)
        next_s.ps = s.div + PH_OFFSET;
    end
    else
    begin
      if (s.gap != '1)
        next_s.gap = s.gap + 1'b1;
      if (s.gap >= GAP_W'(DCLK_LIMIT_CYC))
        next_s.present = 1'b0;
    end

    // Capture on both edges, move through the phase-selected mux
    if (!s.present)
    begin
      next_s.hold_full = 1'b0;
      next_s.pend = 2'h0;
    end
    else
    begin
      if (dck_edge)
      begin
        next_s.hold_a = s.port[PORT_A_BIT] ? a_s : ZERO_WORD;
        next_s.hold_b = s.port[PORT_B_BIT] ? b_s : ZERO_WORD;
        next_s.hold_full = 1'b1;
      end
      if (xfer)
      begin
        next_s.pair_a = s.hold_a;
        next_s.pair_b = s.hold_b;
        next_s.hold_full = 1'b0;
        next_s.pend = single ? 2'h1 : 2'h2;
      end
      else if (push_fire)
        next_s.pend = s.pend - 2'h1;
    end

    // Converter code: two's complement, so mid-scale is code zero
    if (fq.pop_valid && dac_ready)
    begin
      next_s.code = fq.pop_data;
      next_s.code_vld = 1'b1;
    end
    if (mute)
      next_s.code = MID_CODE;

    // Serial register port
    case (s.spi_st)
      SPI_IDLE:
      begin
        next_s.cnt = '0;
        next_s.rd = 1'b0;
        if (!cs_n_s)
          next_s.spi_st = SPI_SHIFT;
      end
      SPI_SHIFT:
      begin
        if (cs_n_s)
          next_s.spi_st = SPI_IDLE;
        else if (sck_rise)
        begin
          next_s.sin = {s.sin[SPI_BITS-2:0], sdi_s};
          next_s.cnt = s.cnt + 1'b1;
          if (hdr_load)
          begin
            next_s.rd = frame_byte[7];
            next_s.sout = rd_mux(frame_byte[6:0]);
          end
          if (s.cnt == SPI_CNT_W'(SPI_BITS - 1))
            next_s.spi_st = SPI_DONE;
        end
        else if (sck_fall && s.cnt > SPI_CNT_W'(SPI_HDR_BITS))
          next_s.sout = {s.sout[6:0], 1'b0};
      end
      SPI_DONE:
      begin
        if (cs_n_s)
          next_s.spi_st = SPI_IDLE;
      end
      default: next_s.spi_st = SPI_IDLE;
    endcase

    // Register writes win over the automatic phase update
    if (spi_wr)
    begin
      case (s.sin[13:7])
        ADDR_CLK_CTL:
        begin
          next_s.clk_en = frame_byte[CLK_EN_BIT];
          next_s.q = frame_byte[CLK_Q_BIT];
          next_s.trim = frame_byte[TRIM_MSB:TRIM_LSB];
        end
        ADDR_PORT_CTL: next_s.port = frame_byte[3:0];
        ADDR_PH_CTL:
        begin
          next_s.msyn = frame_byte[MSYN_BIT];
          if (frame_byte[MSYN_BIT])
            next_s.ps = frame_byte[PS_MSB:0];
        end
        default: next_s.msyn = s.msyn;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int A_LIM = 24;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst || !ce);

  a_rx_gate: assert property ($fell(s.clk_en) |-> ##[1:A_LIM] !s.present)
    else $error("present stayed with receiver off");
  a_present_fast: assert property ($rose(s.present) |->
    $past(s.gap) < GAP_W'(DCLK_LIMIT_CYC))
    else $error("present set on a slow clock");
  a_mute_noclk: assert property (!s.present && !pattern_gen_enable |=>
    dac_code == MID_CODE)
    else $error("code not mid-scale without data clock");
  a_mute_upd: assert property (!s.port[UPD_BIT] |=> dac_code == MID_CODE)
    else $error("code not mid-scale while muted");
  a_port_a_off: assert property (dck_edge && s.present &&
    !s.port[PORT_A_BIT] |=> s.hold_a == ZERO_WORD)
    else $error("disabled port A gave data");
  a_port_b_off: assert property (dck_edge && s.present &&
    !s.port[PORT_B_BIT] |=> s.hold_b == ZERO_WORD)
    else $error("disabled port B gave data");
  a_order_ab: assert property (push_fire && s.pend == 2'h2 |=>
    s.pend == 2'h1 || !s.present)
    else $error("port B word did not follow port A");
  a_single_b: assert property (xfer && single |=>
    s.pend == 2'h1 && s.pair_b == $past(s.hold_b))
    else $error("single-port transfer not from port B");
  a_manual_hold: assert property (s.msyn && !spi_wr |=> $stable(s.ps))
    else $error("manual phase moved without a write");
  a_auto_track: assert property (!s.msyn && !spi_wr && dck_rise &&
    s.result[1:0] == s.div |=> s.ps == $past(s.div) + PH_OFFSET)
    else $error("automatic phase did not follow comparators");
  a_quad_match: assert property (s.q |-> tap_sel == 2'h0)
    else $error("quadrature mode delayed the clock");
  a_edge_delay: assert property (!s.q |-> tap_sel != 2'h0)
    else $error("edge-aligned mode lacks clock delay");
  a_read_phase: assert property (hdr_load && frame_byte == {1'b1,
    ADDR_PH_OBS} |=> s.sout == $past(s.result))
    else $error("comparator readback wrong");

  c_present: cover property ($rose(s.present));
  c_dual_pair: cover property (push_fire && s.pend == 2'h2 ##1 push_fire);
  c_single: cover property (xfer && single);
  c_manual_wr: cover property (spi_wr && s.sin[13:7] == ADDR_PH_CTL);

endmodule

/* bench/lsi_src_model.sv */
// Far-side source: drives the DDR data clock and both sample ports
`timescale 1ns/1ps
module lsi_src_model
  import lsi_pkg::*;
(
  input wire logic run,
  input wire logic slow,
  input wire logic single,
  output logic dclk,
  output lsi_pkg::lsi_word_t a_word,
  output lsi_pkg::lsi_word_t b_word
);
  logic [11:0] k;
  initial
  begin
    dclk = 1'b0;
    a_word = 16'h0000;
    b_word = 16'h0000;
    k = 12'h000;
    // Phase offset keeps this clock's edges off the core_clk edges
    #3;
    forever
    begin
      #(slow ? 80 : 32);
      if (run)
      begin
        // Words change with the clock edge, one pair per edge
        dclk = ~dclk;
        k = k + 12'h001;
        // Port A carries no data in single-port use
        a_word = single ? ~a_word : {4'hA, k};
        b_word = {4'hB, k};
      end
      else
      begin
        // Clock stands still; released lines do not keep old values
        dclk = 1'b0;
        a_word = ~a_word;
        b_word = ~b_word;
      end
    end
  end
endmodule

/* bench/test_lsi_top.sv */
// Self-checking bench for the sample input synchronizer top
`timescale 1ns/1ps
module test_lsi_top;
  import lsi_pkg::*;
  logic core_clk, rst, spi_cs_n, spi_sck, spi_sdi, dac_ready, pgen;
  logic spi_sdo, spi_sdo_oe, dclk, dac_code_valid, data_clock_present;
  logic data_clock_rx_enable, port_a_rx_enable, port_b_rx_enable;
  logic run, slow, single;
  lsi_word_t pa, pb, dac_code;
  lsi_word_t codes[$];
  logic [7:0] rd;
  logic [1:0] ph;
  logic oe_seen;
  int n_mismatch, checks, cycles;

  lsi_top #(.DCLK_LIMIT_CYC(9)) dut (
    .core_clk(core_clk), .rst(rst), .ce(1'b1),
    .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .ddr_capture_clock_pair(dclk), .first_port_pairs(pa),
    .second_port_pairs(pb), .pattern_gen_enable(pgen),
    .dac_ready(dac_ready), .dac_code(dac_code),
    .dac_code_valid(dac_code_valid),
    .data_clock_present(data_clock_present),
    .data_clock_rx_enable(data_clock_rx_enable),
    .port_a_rx_enable(port_a_rx_enable),
    .port_b_rx_enable(port_b_rx_enable)
  );

  lsi_src_model src (
    .run(run), .slow(slow), .single(single),
    .dclk(dclk), .a_word(pa), .b_word(pb)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (dac_code_valid === 1'b1)
      codes.push_back(dac_code);
    cycles++;
    // Whole sequence needs well under half of this
    if (cycles == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One 16-bit frame; sck levels last 4 core cycles, sdo taken before rise
  task spi(input logic [15:0] f);
    int i;
    spi_cs_n = 1'b0;
    tick(2);
    for (i = 15; i >= 0; i--)
    begin
      spi_sdi = f[i];
      spi_sck = 1'b0;
      tick(4);
      if (i < 8)
        rd[i] = spi_sdo;
      if (i == 0)
        oe_seen = spi_sdo_oe;
      spi_sck = 1'b1;
      tick(4);
    end
    spi_sck = 1'b0;
    tick(6);
    spi_cs_n = 1'b1;
    tick(4);
  endtask

  task wr(input logic [6:0] a, input logic [7:0] d);
    spi({1'b0, a, d});
  endtask

  task rdchk(input logic [6:0] a, input logic [7:0] exp);
    spi({1'b1, a, 8'h00});
    check({8'h00, rd}, {8'h00, exp});
    check({15'h0, oe_seen}, 16'h0001);
  endtask

  // Mode 0 dual, 1 dual with port A off, 2 single-port
  task traffic(input logic [7:0] cfg, input int mode);
    int i;
    single = cfg[SP_BIT];
    wr(ADDR_PORT_CTL, cfg);
    tick(20);
    codes.delete();
    tick(60);
    // Stall the consumer long enough to fill the FIFO in the dual-port modes; single-port pushes only about 10 words
    dac_ready = 1'b0;
    tick(40);
    dac_ready = 1'b1;
    tick(100);
    check(16'(codes.size() > 4), 16'h0001);
    for (i = 0; i < codes.size(); i++)
    begin
      if (mode == 2)
        check({12'h000, codes[i][15:12]}, 16'h000B);
      else if (i > 0 && codes[i][15:12] == 4'hB)
        check(codes[i-1], mode == 1 ? 16'h0000 :
          {4'hA, codes[i][11:0]});
    end
  endtask

  task conclude();
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_sdi = 1'b0;
    dac_ready = 1'b1;
    pgen = 1'b0;
    run = 1'b0;
    slow = 1'b0;
    single = 1'b0;
    n_mismatch = 0;
    checks = 0;
    cycles = 0;
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    tick(2);
    rdchk(ADDR_CLK_CTL, REG_RESET);
    rdchk(ADDR_PORT_CTL, REG_RESET);
    wr(7'h07, 8'hFF);
    rdchk(7'h07, 8'h00);
    wr(ADDR_CLK_CTL, 8'h01);
    check({15'h0, data_clock_rx_enable}, 16'h0001);
    run = 1'b1;
    // Scaled settling wait before samples are used
    tick(40);
    check({15'h0, data_clock_present}, 16'h0001);
    wr(ADDR_CLK_CTL, 8'h77);
    rdchk(ADDR_CLK_CTL, 8'h77);
    wr(ADDR_CLK_CTL, 8'h03);
    rdchk(ADDR_CLK_CTL, 8'h03);
    // Steady clock: comparator samples alike, phase is newest plus offset
    spi({1'b1, ADDR_PH_OBS, 8'h00});
    check({8'h00, rd}, {8'h00, {4{rd[1:0]}}});
    ph = rd[1:0] + PH_OFFSET;
    rdchk(ADDR_PH_CTL, {6'h00, ph});
    wr(ADDR_PH_CTL, {6'h00, ~ph});
    rdchk(ADDR_PH_CTL, {6'h00, ph});
    // Manual phase written along with the override bit
    wr(ADDR_PH_CTL, 8'h06);
    rdchk(ADDR_PH_CTL, 8'h06);
    traffic(8'h0B, 0);
    check({14'h0, port_a_rx_enable, port_b_rx_enable}, 16'h0003);
    traffic(8'h0A, 1);
    traffic(8'h0E, 2);
    check({15'h0, port_a_rx_enable}, 16'h0000);
    wr(ADDR_PORT_CTL, 8'h06);
    tick(10);
    check(dac_code, MID_CODE);
    wr(ADDR_PORT_CTL, 8'h0C);
    tick(100);
    check(dac_code, ZERO_WORD);
    wr(ADDR_PORT_CTL, 8'h0E);
    tick(100);
    // Pattern generator on: a lost clock no longer forces mid-scale
    pgen = 1'b1;
    run = 1'b0;
    tick(40);
    check(16'(dac_code != MID_CODE), 16'h0001);
    pgen = 1'b0;
    tick(2);
    check(dac_code, MID_CODE);
    run = 1'b1;
    tick(40);
    check({15'h0, data_clock_present}, 16'h0001);
    // Too slow a clock reads as absent and mutes the output
    slow = 1'b1;
    tick(100);
    check({15'h0, data_clock_present}, 16'h0000);
    check(dac_code, MID_CODE);
    rdchk(ADDR_CLK_CTL, 8'h01);
    // Receiver switched off under a running clock drops presence
    slow = 1'b0;
    tick(40);
    check({15'h0, data_clock_present}, 16'h0001);
    wr(ADDR_CLK_CTL, 8'h00);
    tick(20);
    check({15'h0, data_clock_present}, 16'h0000);
    check({15'h0, data_clock_rx_enable}, 16'h0000);
    run = 1'b0;
    conclude();
  end
endmodule
